// File: core/dpc_pkg.sv
// Package: constants and types for the core power, clock and reset controller
package dpc_pkg;

    // ******************************************************
    // APB register map
    // ******************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IMASK = 8'h04;
    localparam logic [7:0] ADDR_EDGE = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_PEND = 8'h14;
    localparam logic [7:0] ADDR_MODE_STATUS_REG = 8'h18;

    // CTRL fields
    localparam int CTRL_CLOCK_OUTPUT_DISABLE_BIT = 0;
    localparam int CTRL_CTXCLR_BIT = 1;
    localparam int CTRL_BOOT_BIT = 2;
    // CMD fields
    localparam int CMD_PDFORCE_BIT = 0;
    localparam int CMD_IDLE_BIT = 1;
    localparam int CMD_DOZE_BIT = 2;
    localparam int CMD_DIV_LSB = 4;

    // ******************************************************
    // Reset values and counts
    // ******************************************************
    localparam logic [10:0] IMASK_RESET = 11'h000;
    localparam logic [2:0] EDGE_RESET = 3'h0;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [15:0] MODE_STATUS_REG_RESET = 16'h0000;
    localparam logic [13:0] BOOT_ADDR = 14'h0000;
    localparam int NUM_IRQ = 11;
    localparam int WAKE_INPUT_CLOCKS = 200;
    localparam int INPUT_PER_CYCLE = 2;
    localparam int WAKE_CYCLES = WAKE_INPUT_CLOCKS * INPUT_PER_CYCLE;
    localparam int SYS_CLK_MHZ = 200;
    localparam int CORE_CYCLE_PS = 12500;

    // Interrupt index: 0 is power down (highest), 10 is lowest
    localparam int IRQ_PWRDN = 0;
    localparam int IRQ_GENERAL = 1;
    localparam int IRQ_NUM_ONE = 8;
    localparam int IRQ_NUM_ZERO = 9;

    // Slow idle divisor codes: n = 16 << code
    typedef enum logic [1:0]
    {
        DIV_16 = 2'b00,
        DIV_32 = 2'b01,
        DIV_64 = 2'b10,
        DIV_128 = 2'b11
    } dpc_div_t;

    typedef enum logic [2:0]
    {
        ST_RUN = 3'b000,
        ST_IDLE = 3'b001,
        ST_PD_HANDLER = 3'b010,
        ST_DORMANT = 3'b011,
        ST_WAKE = 3'b100,
        ST_BOOT = 3'b101
    } dpc_state_t;

    typedef struct packed
    {
        logic ext_irq_general;
        logic ext_irq_level_one;
        logic ext_irq_level_zero;
        logic ext_irq_edge;
        logic ext_irq_num_one;
        logic ext_irq_num_zero;
    } dpc_ext_irq_t;

    typedef struct packed
    {
        logic valid;
        logic [3:0] index;
        logic [13:0] vector;
    } dpc_vector_t;

endpackage

// File: core/dpc_clk_div.sv
// Clock divider: full-rate or slow-idle enable pulses for core and derived clocks
`timescale 1ns/1ps
module dpc_clk_div
#(
    parameter int CNT_W = 7
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic slow_req,
    input wire dpc_pkg::dpc_div_t div_code,
    output logic cycle_en,
    output logic slow_active,
    output logic clk_level
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] limit;
    logic toggle_reg;

    always_comb
    begin
        limit = CNT_W'((8'd16 << div_code) - 8'd1);
    end

    // Slow mode starts on a cycle_en boundary but stops as soon as slow_req drops, so the last divided period can be short
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            slow_active <= 1'b0;
        end
        else if (cycle_en)
        begin
            slow_active <= slow_req;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cnt_reg <= '0;
        end
        else if (!slow_active || cnt_reg == limit || !slow_req)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    assign cycle_en = !slow_active || cnt_reg == limit || !slow_req;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            toggle_reg <= 1'b0;
        end
        else if (cycle_en)
        begin
            toggle_reg <= ~toggle_reg;
        end
    end

    assign clk_level = toggle_reg;

endmodule

// File: core/dpc_ctrl.sv
// Power, clock, reset and interrupt-wake controller for one processor core
// Contract
// - Eleven interrupts plus reset, prioritised, maskable except power down and reset.
// - General and both numbered external interrupts selectable level or edge.
// - Software force bit starts power down; handler runs before optional dormancy.
// - Leaving power down resumes execution in 200 input clock cycles.
// - Control bit picks saved-context resume or cleared-context restart after power down.
// - Reset input also ends power down.
// - Idle stalls until unmasked interrupt, then continues after the idle.
// - Host port, byte transfer and autobuffer cycle steals continue during idle.
// - Slow idle divides core clock by 16, 32, 64 or 128.
// - Serial, output and timer clocks divided by the same ratio in slow idle.
// - Idle without divisor is standard idle, undivided, one-cycle response.
// - Slow idle wake may take up to n core cycles.
// - Core cycle runs at twice input clock rate; one cycle per instruction.
// - Cycle-rate clock output gated by a disable bit.
// - Later resets impose no stabilisation wait.
// - Reset empties stacks, masks all interrupts, clears mode status register.
// - Reset release with boot set and no bus request boots, then fetches 0x0000; reset clears the boot bit, so ST_BOOT moves to ST_RUN without a boot.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module dpc_ctrl
#(
    parameter int WAKE_CYCLES = dpc_pkg::WAKE_CYCLES
)
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire dpc_pkg::dpc_ext_irq_t EXT_IRQ,
    input wire logic [4:0] INT_IRQ,
    input wire logic BUS_REQUEST,
    input wire logic BOOT_DONE,
    input wire logic STEAL_REQ,
    output logic CORE_RUN,
    output logic CYCLE_CLOCK_OUTPUT,
    output logic DERIVED_CLK_EN,
    output logic STEAL_GRANT,
    output logic CTX_CLEAR,
    output logic STACK_EMPTY,
    output logic VECTOR_VALID,
    output logic [13:0] VECTOR_ADDR,
    output logic POWERED_DOWN
);

    // ******************************************************
    // Registers
    // ******************************************************
    logic [2:0] ctrl_reg;
    logic [10:0] imask_reg;
    logic [2:0] edge_reg;
    logic [15:0] mode_status_reg_reg;
    logic [10:0] pend_reg;
    logic [10:0] pend_next;
    logic [10:0] raw_irq;
    logic [10:0] raw_prev_reg;
    logic [10:0] eligible;
    logic idle_div_reg;
    dpc_pkg::dpc_div_t div_reg;
    dpc_pkg::dpc_state_t state_reg;
    logic [9:0] wake_cnt_reg;
    dpc_pkg::dpc_vector_t pick;
    logic cycle_en;
    logic slow_active;
    logic clk_level;
    logic wr;
    logic rd;
    logic ack;
    logic force_pd;
    logic pd_handled_reg;

    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;

    // Raw sources: index 0 power down, then external and internal
    always_comb
    begin
        raw_irq = {INT_IRQ[4] | INT_IRQ[3], EXT_IRQ.ext_irq_num_zero, EXT_IRQ.ext_irq_num_one, INT_IRQ[2],
                   EXT_IRQ.ext_irq_edge, INT_IRQ[1:0], EXT_IRQ.ext_irq_level_zero, EXT_IRQ.ext_irq_level_one,
                   EXT_IRQ.ext_irq_general, force_pd};
    end

    // ******************************************************
    // Interrupt latching and priority
    // ******************************************************
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            raw_prev_reg <= '0;
        end
        else
        begin
            raw_prev_reg <= raw_irq;
        end
    end

    always_comb
    begin
        pend_next = pend_reg;
        if (ack)
        begin
            pend_next[pick.index] = 1'b0;
        end
        if (edge_reg[0] && raw_irq[dpc_pkg::IRQ_GENERAL] && !raw_prev_reg[dpc_pkg::IRQ_GENERAL])
        begin
            pend_next[dpc_pkg::IRQ_GENERAL] = 1'b1;
        end
        if (edge_reg[1] && raw_irq[dpc_pkg::IRQ_NUM_ONE] && !raw_prev_reg[dpc_pkg::IRQ_NUM_ONE])
        begin
            pend_next[dpc_pkg::IRQ_NUM_ONE] = 1'b1;
        end
        if (edge_reg[2] && raw_irq[dpc_pkg::IRQ_NUM_ZERO] && !raw_prev_reg[dpc_pkg::IRQ_NUM_ZERO])
        begin
            pend_next[dpc_pkg::IRQ_NUM_ZERO] = 1'b1;
        end
        if (force_pd)
        begin
            pend_next[dpc_pkg::IRQ_PWRDN] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            pend_reg <= '0;
        end
        else
        begin
            pend_reg <= pend_next;
        end
    end

    // Level sources pass through; edge-configured ones use the latch
    always_comb
    begin
        eligible = raw_irq & ~11'h001;
        eligible[dpc_pkg::IRQ_GENERAL] = edge_reg[0] ? pend_reg[dpc_pkg::IRQ_GENERAL] : raw_irq[dpc_pkg::IRQ_GENERAL];
        eligible[dpc_pkg::IRQ_NUM_ONE] = edge_reg[1] ? pend_reg[dpc_pkg::IRQ_NUM_ONE] : raw_irq[dpc_pkg::IRQ_NUM_ONE];
        eligible[dpc_pkg::IRQ_NUM_ZERO] = edge_reg[2] ? pend_reg[dpc_pkg::IRQ_NUM_ZERO] : raw_irq[dpc_pkg::IRQ_NUM_ZERO];
        eligible = eligible & imask_reg;
        eligible[dpc_pkg::IRQ_PWRDN] = pend_reg[dpc_pkg::IRQ_PWRDN];
    end

    always_comb
    begin
        pick = '0;
        for (int i = dpc_pkg::NUM_IRQ - 1; i >= 0; i--)
        begin
            if (eligible[i])
            begin
                pick.valid = 1'b1;
                pick.index = 4'(i);
                pick.vector = (i == 0) ? 14'h002c : 14'(i * 4);
            end
        end
    end

    // One vector per strobe; slow idle first returns to full rate
    assign ack = pick.valid && cycle_en && !VECTOR_VALID
                 && (state_reg == dpc_pkg::ST_RUN || (state_reg == dpc_pkg::ST_IDLE && !slow_active));
    assign force_pd = wr && PADDR == dpc_pkg::ADDR_CMD && PWDATA[dpc_pkg::CMD_PDFORCE_BIT];

    // ******************************************************
    // Sequencer
    // ******************************************************
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            state_reg <= dpc_pkg::ST_BOOT;
            wake_cnt_reg <= '0;
            pd_handled_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                dpc_pkg::ST_BOOT:
                begin
                    if (!ctrl_reg[dpc_pkg::CTRL_BOOT_BIT] || (BOOT_DONE && !BUS_REQUEST))
                    begin
                        state_reg <= dpc_pkg::ST_RUN;
                    end
                end
                dpc_pkg::ST_RUN:
                begin
                    if (ack && pick.index == 4'(dpc_pkg::IRQ_PWRDN))
                    begin
                        state_reg <= dpc_pkg::ST_PD_HANDLER;
                        pd_handled_reg <= 1'b1;
                    end
                    else if (wr && PADDR == dpc_pkg::ADDR_CMD && PWDATA[dpc_pkg::CMD_IDLE_BIT])
                    begin
                        state_reg <= dpc_pkg::ST_IDLE;
                    end
                end
                dpc_pkg::ST_PD_HANDLER:
                begin
                    if (wr && PADDR == dpc_pkg::ADDR_CMD && PWDATA[dpc_pkg::CMD_DOZE_BIT])
                    begin
                        state_reg <= dpc_pkg::ST_DORMANT;
                    end
                    else if (wr && PADDR == dpc_pkg::ADDR_CMD && PWDATA[dpc_pkg::CMD_IDLE_BIT])
                    begin
                        state_reg <= dpc_pkg::ST_RUN;
                    end
                end
                dpc_pkg::ST_DORMANT:
                begin
                    if (|(raw_irq & imask_reg))
                    begin
                        state_reg <= dpc_pkg::ST_WAKE;
                        wake_cnt_reg <= 10'(WAKE_CYCLES - 1);
                    end
                end
                dpc_pkg::ST_WAKE:
                begin
                    if (wake_cnt_reg == 10'h000)
                    begin
                        state_reg <= dpc_pkg::ST_RUN;
                    end
                    else
                    begin
                        wake_cnt_reg <= wake_cnt_reg - 10'h001;
                    end
                end
                dpc_pkg::ST_IDLE:
                begin
                    if (ack && !slow_active)
                    begin
                        state_reg <= dpc_pkg::ST_RUN;
                    end
                end
                default:
                begin
                    state_reg <= dpc_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ******************************************************
    // APB registers
    // ******************************************************
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ctrl_reg <= dpc_pkg::CTRL_RESET;
            imask_reg <= dpc_pkg::IMASK_RESET;
            edge_reg <= dpc_pkg::EDGE_RESET;
            mode_status_reg_reg <= dpc_pkg::MODE_STATUS_REG_RESET;
            idle_div_reg <= 1'b0;
            div_reg <= dpc_pkg::DIV_16;
        end
        else
        begin
            if (wr && PADDR == dpc_pkg::ADDR_CTRL)
            begin
                ctrl_reg <= PWDATA[2:0];
            end
            if (wr && PADDR == dpc_pkg::ADDR_IMASK)
            begin
                imask_reg <= PWDATA[10:0];
            end
            if (wr && PADDR == dpc_pkg::ADDR_EDGE)
            begin
                edge_reg <= PWDATA[2:0];
            end
            if (wr && PADDR == dpc_pkg::ADDR_MODE_STATUS_REG)
            begin
                mode_status_reg_reg <= PWDATA[15:0];
            end
            if (wr && PADDR == dpc_pkg::ADDR_CMD && PWDATA[dpc_pkg::CMD_IDLE_BIT] && state_reg == dpc_pkg::ST_RUN)
            begin
                idle_div_reg <= PWDATA[3];
                div_reg <= dpc_pkg::dpc_div_t'(PWDATA[dpc_pkg::CMD_DIV_LSB +: 2]);
            end
            else if (state_reg != dpc_pkg::ST_IDLE)
            begin
                idle_div_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            PRDATA <= '0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && PADDR > dpc_pkg::ADDR_MODE_STATUS_REG;
            PRDATA <= '0;
            if (PSEL && !PENABLE && !PWRITE)
            begin
                unique case (PADDR)
                    dpc_pkg::ADDR_CTRL: PRDATA <= {29'h0, ctrl_reg};
                    dpc_pkg::ADDR_IMASK: PRDATA <= {21'h0, imask_reg};
                    dpc_pkg::ADDR_EDGE: PRDATA <= {29'h0, edge_reg};
                    dpc_pkg::ADDR_STATUS: PRDATA <= {26'h0, slow_active, idle_div_reg, 1'b0, state_reg};
                    dpc_pkg::ADDR_PEND: PRDATA <= {21'h0, pend_reg};
                    dpc_pkg::ADDR_MODE_STATUS_REG: PRDATA <= {16'h0, mode_status_reg_reg};
                    default: PRDATA <= '0;
                endcase
            end
        end
    end

    // ******************************************************
    // Clock division and outputs
    // ******************************************************
    dpc_clk_div u_div
    (
        .sys_clk(SYS_CLK),
        .reset(RESET),
        .slow_req(idle_div_reg && state_reg == dpc_pkg::ST_IDLE && !pick.valid),
        .div_code(div_reg),
        .cycle_en(cycle_en),
        .slow_active(slow_active),
        .clk_level(clk_level)
    );

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            CORE_RUN <= 1'b0;
            CYCLE_CLOCK_OUTPUT <= 1'b0;
            DERIVED_CLK_EN <= 1'b0;
            STEAL_GRANT <= 1'b0;
            CTX_CLEAR <= 1'b1;
            STACK_EMPTY <= 1'b1;
            VECTOR_VALID <= 1'b0;
            VECTOR_ADDR <= dpc_pkg::BOOT_ADDR;
            POWERED_DOWN <= 1'b0;
        end
        else
        begin
            CORE_RUN <= state_reg == dpc_pkg::ST_RUN || state_reg == dpc_pkg::ST_PD_HANDLER;
            CYCLE_CLOCK_OUTPUT <= clk_level && !ctrl_reg[dpc_pkg::CTRL_CLOCK_OUTPUT_DISABLE_BIT];
            DERIVED_CLK_EN <= cycle_en && state_reg != dpc_pkg::ST_DORMANT;
            STEAL_GRANT <= STEAL_REQ && state_reg != dpc_pkg::ST_DORMANT && cycle_en;
            CTX_CLEAR <= state_reg == dpc_pkg::ST_WAKE && wake_cnt_reg == 10'h000
                         && ctrl_reg[dpc_pkg::CTRL_CTXCLR_BIT];
            STACK_EMPTY <= 1'b0;
            VECTOR_VALID <= ack || (state_reg == dpc_pkg::ST_BOOT && ctrl_reg[dpc_pkg::CTRL_BOOT_BIT]
                            && BOOT_DONE && !BUS_REQUEST);
            VECTOR_ADDR <= ack ? pick.vector : dpc_pkg::BOOT_ADDR;
            POWERED_DOWN <= state_reg == dpc_pkg::ST_DORMANT || state_reg == dpc_pkg::ST_WAKE;
        end
    end

endmodule

// File: tb/dpc_monitor.sv
// Checker: assertions on the controller ports
`timescale 1ns/1ps
module dpc_monitor
#(
    parameter int WAKE_CYCLES = dpc_pkg::WAKE_CYCLES
)
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic STEAL_REQ,
    input wire logic CORE_RUN,
    input wire logic CYCLE_CLOCK_OUTPUT,
    input wire logic STEAL_GRANT,
    input wire logic CTX_CLEAR,
    input wire logic STACK_EMPTY,
    input wire logic VECTOR_VALID,
    input wire logic [13:0] VECTOR_ADDR,
    input wire logic POWERED_DOWN
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // ****
    // Helper state
    // ****
    logic clock_output_disable_reg;
    logic pd_seen_reg;
    int stop_cnt_reg;
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            clock_output_disable_reg <= 1'b0;
        else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == dpc_pkg::ADDR_CTRL)
            clock_output_disable_reg <= PWDATA[0];
    end
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET || CORE_RUN)
            pd_seen_reg <= 1'b0;
        else if (POWERED_DOWN)
            pd_seen_reg <= 1'b1;
    end
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET || CORE_RUN)
            stop_cnt_reg <= 0;
        else
            stop_cnt_reg <= stop_cnt_reg + 1;
    end
    // ****
    // Assertions
    // ****
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    apb_slverr_a: assert property (PSEL && PENABLE && PREADY && PADDR > 8'h18 |-> PSLVERR)
        else $error("unmapped access without error");
    reset_state_a: assert property ($fell(RESET) |-> STACK_EMPTY && CTX_CLEAR && !POWERED_DOWN)
        else $error("wrong state after reset");
    vec_pulse_a: assert property (VECTOR_VALID |=> !VECTOR_VALID)
        else $error("vector strobe too long");
    vec_range_a: assert property (VECTOR_VALID |-> VECTOR_ADDR == 14'h002c ||
        (VECTOR_ADDR[1:0] == 2'b00 && VECTOR_ADDR >= 14'h0004 && VECTOR_ADDR <= 14'h0028))
        else $error("bad vector address");
    pd_halt_a: assert property (POWERED_DOWN |-> !CORE_RUN && !VECTOR_VALID)
        else $error("core active while powered down");
    clko_off_a: assert property (clock_output_disable_reg && $past(clock_output_disable_reg) |-> !CYCLE_CLOCK_OUTPUT)
        else $error("clock output not gated");
    steal_ok_a: assert property (STEAL_REQ [*3] ##0 !POWERED_DOWN |-> STEAL_GRANT)
        else $error("steal not granted");
    wake_delay_a: assert property ($rose(CORE_RUN) && pd_seen_reg |-> stop_cnt_reg >= WAKE_CYCLES)
        else $error("wake from power down too early");
endmodule
bind dpc_ctrl dpc_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) i_mon (.*);

// File: tb/dpc_irq_src.sv
// Interrupt source model: holds each request until its vector is taken
`timescale 1ns/1ps
module dpc_irq_src
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] req,
    input wire logic vec_valid,
    input wire logic [13:0] vec_addr,
    output dpc_pkg::dpc_ext_irq_t irq
);
    localparam logic [13:0] VEC [6] = '{14'h0024, 14'h0020, 14'h0018, 14'h000c, 14'h0008, 14'h0004};
    logic [5:0] done_reg;
    logic [5:0] hit;
    always_comb
    begin
        for (int b = 0; b < 6; b++)
            hit[b] = vec_valid && vec_addr == VEC[b];
    end
    always_ff @(posedge clk)
    begin
        if (reset)
            done_reg <= 6'h00;
        else
            done_reg <= req & (done_reg | hit);
    end
    // Request drops when its vector is taken and stays low until req is released
    assign irq = req & ~done_reg & ~hit;
endmodule

// File: tb/tb.sv
// Testbench: APB driven tests of the power, clock and reset controller
`timescale 1ns/1ps
module tb;
    localparam int WK = 8;
    localparam logic [7:0] RA [4] = '{8'h00, 8'h04, 8'h08, 8'h18};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, steal = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] req = 6'h00;
    logic pready, pslverr, run, clko, den, grant, ctxc, vv, pdn, err;
    logic [13:0] vaddr;
    dpc_pkg::dpc_ext_irq_t ext_irq;
    int err_total = 0, total_checks = 0, cyc = 0, n, f, g, k;
    initial forever #2.5 clk = ~clk;
    dpc_irq_src i_src (.clk(clk), .reset(rst), .req(req), .vec_valid(vv), .vec_addr(vaddr), .irq(ext_irq));
    dpc_ctrl #(.WAKE_CYCLES(WK)) i_dut (.SYS_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_IRQ(ext_irq), .INT_IRQ(5'h00), .BUS_REQUEST(1'b0), .BOOT_DONE(1'b1), .STEAL_REQ(steal),
        .CORE_RUN(run), .CYCLE_CLOCK_OUTPUT(clko), .DERIVED_CLK_EN(den), .STEAL_GRANT(grant),
        .CTX_CLEAR(ctxc), .STACK_EMPTY(), .VECTOR_VALID(vv), .VECTOR_ADDR(vaddr), .POWERED_DOWN(pdn));
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wvec(input logic [13:0] exp, input int lim);
        n = 0;
        while (vv !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(vaddr), 32'(exp), "vector");
        @(posedge clk);
    endtask
    task automatic gap(output int p);
        repeat (3)
        begin
            p = 0;
            do
            begin
                @(posedge clk);
                p++;
            end
            while (den !== 1'b1 && p < 2000);
        end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            conclude();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (RA[i])
        begin
            apb(1'b0, RA[i], 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(err), 32'h1, "unmapped");
        chk(32'(vaddr), 32'h0, "boot vector");
        apb(1'b1, 8'h04, 32'h7ff);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h7ff, "mask");
        req <= 6'h30;
        wvec(14'h0004, 100);
        wvec(14'h0008, 100);
        req <= 6'h00;
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h0c, 32'h2);
        req <= 6'h08;
        steal <= 1'b1;
        repeat (20) @(posedge clk);
        chk(32'(run), 32'h0, "idle hold");
        chk(32'(grant), 32'h1, "steal");
        apb(1'b1, 8'h04, 32'h8);
        wvec(14'h000c, 50);
        steal <= 1'b0;
        req <= 6'h00;
        chk(32'(run), 32'h1, "idle exit");
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h04, 32'h0);
        req <= 6'h20;
        @(posedge clk);
        req <= 6'h00;
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(rd[1]), 32'h1, "edge latch");
        apb(1'b1, 8'h04, 32'h2);
        wvec(14'h0004, 50);
        apb(1'b1, 8'h08, 32'h0);
        gap(f);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, 8'h0c, 32'h0a | 32'(c << 4));
            gap(g);
            chk(32'(g), 32'(f * (16 << c)), "slow gap");
            req <= 6'h20;
            wvec(14'h0004, f * (16 << c) + 20);
            req <= 6'h00;
            apb(1'b0, 8'h10, 32'h0);
            chk(32'(rd[5]), 32'h0, "full rate");
        end
        apb(1'b1, 8'h00, 32'h1);
        @(posedge clk);
        k = 0;
        repeat (30)
        begin
            @(posedge clk);
            k += 32'(clko !== 1'b0);
        end
        chk(32'(k), 32'h0, "clock gated");
        apb(1'b1, 8'h00, 32'h2);
        k = 0;
        repeat (30)
        begin
            @(posedge clk);
            k += 32'(clko === 1'b1);
        end
        chk(32'(k > 0), 32'h1, "clock out");
        apb(1'b1, 8'h0c, 32'h1);
        wvec(14'h002c, 50);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(rd[2:0]), 32'(dpc_pkg::ST_PD_HANDLER), "handler");
        apb(1'b1, 8'h0c, 32'h4);
        repeat (3) @(posedge clk);
        chk(32'(pdn), 32'h1, "dormant");
        req <= 6'h20;
        k = 0;
        g = 0;
        while (run !== 1'b1 && k < 2000)
        begin
            @(posedge clk);
            k++;
            g |= 32'(ctxc === 1'b1);
        end
        req <= 6'h00;
        chk(32'(k >= WK && k < WK + 20), 32'h1, "wake time");
        chk(32'(g), 32'h1, "context clear");
        apb(1'b1, 8'h0c, 32'h1);
        wvec(14'h002c, 50);
        apb(1'b1, 8'h0c, 32'h4);
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(pdn), 32'h0, "reset wake");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0, "mask cleared");
        conclude();
    end
endmodule
